// File: wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
// register byte offsets on the bus
`define WDT_OFF_COUNT 12'h000
`define WDT_OFF_PERIOD 12'h004
`define WDT_OFF_CTRL 12'h008
`define WDT_OFF_CTRL2 12'h00c
`define WDT_OFF_STATUS 12'h010
`define WDT_OFF_MASK 12'h014
// control register fields
`define WDT_CTRL_SOFT 11
`define WDT_CTRL_FREE 10
`define WDT_CTRL_PCNT_HI 9
`define WDT_CTRL_PCNT_LO 6
`define WDT_CTRL_FIELD_HI 3
`define WDT_CTRL_FIELD_LO 0
// second control register fields
`define WDT_CTRL2_FLAG 15
`define WDT_CTRL2_MODE 12
// reset values
`define WDT_RST_COUNT 16'hffff
`define WDT_RST_PERIOD 16'hffff
`define WDT_RST_FIELD 4'hf
`define WDT_RST_MODE 1'b1
`define WDT_RST_PRESCALE 16'hffff
`endif

// File: wdt_pkg.sv
package wdt_pkg;
  // prescaler operating modes
  typedef enum logic {
    PRESCALE_DIRECT,
    PRESCALE_INDIRECT
  } prescale_mode_t;
endpackage

// File: wdt_prescaler.sv
`timescale 1ns/1ps
`include "wdt_cfg.svh"
// ==========================================================
// prescaler: one tick per underflow
module wdt_prescaler (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic reload_i,
  input wire logic mode_i,
  input wire logic [3:0] field_i,
  // result
  output logic tick_o,
  output logic [3:0] direct_cnt_o
);
  logic [15:0] cnt;
  logic [15:0] load_val;

  // indirect code n gives 2^(n+1)-1
  function automatic logic [15:0] indirect_value(input logic [3:0] n);
    indirect_value = 16'hffff >> (4'hf - n);
  endfunction

  // reload value depends on mode
  always_comb begin
    if (mode_i == wdt_pkg::PRESCALE_INDIRECT) begin
      load_val = indirect_value(field_i); // see R9
    end else begin
      load_val = {12'h000, field_i}; // see R8
    end
  end

  // down-count, reload at zero; underflow makes the tick
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= `WDT_RST_PRESCALE;
      tick_o <= 1'b0;
    end else if (reload_i) begin
      cnt <= load_val; // see R13
      tick_o <= 1'b0;
    end else if (run_i) begin
      if (cnt == 16'h0000) begin
        cnt <= load_val; // see R8 see R15
        tick_o <= 1'b1;
      end else begin
        cnt <= cnt - 16'h0001; // see R15
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end

  assign direct_cnt_o = cnt[3:0]; // see R7

  a_tick_at_zero: assert property ( // see R15
    @(posedge mclk_i) disable iff (!rst_n_i)
    run_i && !reload_i && cnt == 16'h0000 |=> tick_o)
    else $error("prescaler underflow gave no tick");
  a_tick_cause: assert property ( // see R15
    @(posedge mclk_i) disable iff (!rst_n_i)
    tick_o |-> $past(run_i) && $past(cnt) == 16'h0000)
    else $error("tick without underflow");
  // the expected load is built another way than the function above
  a_indirect_load: assert property ( // see R9
    @(posedge mclk_i) disable iff (!rst_n_i)
    run_i && !reload_i && cnt == 16'h0000 && mode_i
    |=> {1'b0, cnt} == (17'h0_0002 << $past(field_i)) - 17'h0_0001)
    else $error("indirect reload value wrong");
endmodule

// File: wdt_core.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "wdt_cfg.svh"
// Summary of operation
// R1 - four 16-bit registers: count, reload period, control, second control.
// R2 - the count falls by one on each prescaler underflow.
// R3 - every reload of the count takes the reload period value.
// R4 - in debug halt with both halt bits low the count stops at once.
// R5 - in debug halt with halt-at-zero set the count runs to zero then stops.
// R6 - with run-on-halt set the count ignores debug halt.
// R7 - control bits 9..6 read the prescale counter, meaningful in direct mode.
// R8 - in direct mode the prescaler reloads from the 4-bit field at zero.
// R9 - in indirect mode field code n selects a prescale of 2^(n+1)-1.
// R10 - control bits 15..12 and 5..4 read zero and ignore writes.
// R11 - reset clears both halt bits and sets the field to 1111.
// R12 - reaching zero sets the timeout flag and raises the interrupt; the code raises it only while the mask bit (reset 0) is set.
// R13 - after a timeout count and prescaler reload and counting goes on.
// R14 - the mode bit selects direct at 0, indirect at 1, resetting to 1.
// R15 - in indirect mode one decrement comes per prescaler underflow.
module wdt_core (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // debug halt from the debugger (asynchronous)
  input wire logic debug_halt_i,
  // events
  output logic timeout_pulse_o,
  output logic timeout_interrupt_o
);
  // ==========================================================
  // register state
  logic [15:0] watchdog_count;
  logic [15:0] watchdog_reload_period;
  logic soft_bit;
  logic free_bit;
  logic [3:0] prescale_field;
  logic prescale_mode_select;
  logic timeout_flag;
  logic irq_mask;
  logic [1:0] halt_sync;
  logic halted;
  logic run;
  logic tick;
  logic [3:0] prescale_counter;
  logic at_zero;
  logic timeout;
  logic wr;
  logic rd;
  logic [15:0] ctrl_rd;
  logic [15:0] ctrl2_rd;

  // decode of a bus address, in the setup or the access phase
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && !pwrite_i;

  // ==========================================================
  // debug halt synchroniser; only the second stage is read
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_sync <= 2'b00;
    end else begin
      halt_sync <= {halt_sync[0], debug_halt_i};
    end
  end
  assign halted = halt_sync[1];

  // ==========================================================
  // run enable: halt behaviour chosen by the two halt bits
  always_comb begin
    if (!halted || free_bit) begin
      run = 1'b1; // see R6
    end else if (soft_bit) begin
      run = (watchdog_count != 16'h0000); // see R5
    end else begin
      run = 1'b0; // see R4
    end
  end

  assign at_zero = (watchdog_count == 16'h0000);
  // a tick at zero is the timeout: the counter reloads instead
  assign timeout = run && tick && at_zero; // see R12

  wdt_prescaler u_prescaler (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .run_i(run),
    .reload_i(1'b0),
    .mode_i(prescale_mode_select),
    .field_i(prescale_field),
    .tick_o(tick),
    .direct_cnt_o(prescale_counter)
  );

  // ==========================================================
  // count register; software write wins over a decrement
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_count <= `WDT_RST_COUNT;
    end else if (wr && hit(paddr_i, `WDT_OFF_COUNT)) begin
      watchdog_count <= pwdata_i[15:0]; // see R1
    end else if (timeout) begin
      watchdog_count <= watchdog_reload_period; // see R3 see R13
    end else if (run && tick) begin
      watchdog_count <= watchdog_count - 16'h0001; // see R2
    end
  end

  // period register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_reload_period <= `WDT_RST_PERIOD;
    end else if (wr && hit(paddr_i, `WDT_OFF_PERIOD)) begin
      watchdog_reload_period <= pwdata_i[15:0];
    end
  end

  // control register: reserved bits are simply not stored
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_bit <= 1'b0; // see R11
      free_bit <= 1'b0; // see R11
      prescale_field <= `WDT_RST_FIELD; // see R11
    end else if (wr && hit(paddr_i, `WDT_OFF_CTRL)) begin
      soft_bit <= pwdata_i[`WDT_CTRL_SOFT];
      free_bit <= pwdata_i[`WDT_CTRL_FREE];
      prescale_field <= pwdata_i[`WDT_CTRL_FIELD_HI:`WDT_CTRL_FIELD_LO];
    end
  end

  // second control: mode bit and timeout flag (write one clears)
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_mode_select <= `WDT_RST_MODE; // see R14
    end else if (wr && hit(paddr_i, `WDT_OFF_CTRL2)) begin
      prescale_mode_select <= pwdata_i[`WDT_CTRL2_MODE]; // see R14
    end
  end

  // ==========================================================
  // sticky flag; a timeout in the clearing cycle wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout_flag <= 1'b0;
    end else if (timeout) begin
      timeout_flag <= 1'b1; // see R12
    end else if (wr && (hit(paddr_i, `WDT_OFF_CTRL2)
                        || hit(paddr_i, `WDT_OFF_STATUS))
                 && pwdata_i[`WDT_CTRL2_FLAG]) begin
      timeout_flag <= 1'b0;
    end
  end

  // interrupt mask, bit 15 aligned with the flag
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask <= 1'b0;
    end else if (wr && hit(paddr_i, `WDT_OFF_MASK)) begin
      irq_mask <= pwdata_i[`WDT_CTRL2_FLAG];
    end
  end

  // outputs from flip-flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout_pulse_o <= 1'b0;
      timeout_interrupt_o <= 1'b0;
    end else begin
      timeout_pulse_o <= timeout; // see R12
      timeout_interrupt_o <= (timeout_flag || timeout) && irq_mask;
    end
  end

  // ==========================================================
  // read mux; reserved bits read zero
  always_comb begin
    ctrl_rd = 16'h0000; // see R10
    ctrl_rd[`WDT_CTRL_SOFT] = soft_bit;
    ctrl_rd[`WDT_CTRL_FREE] = free_bit;
    ctrl_rd[`WDT_CTRL_PCNT_HI:`WDT_CTRL_PCNT_LO] = prescale_counter; // see R7
    ctrl_rd[`WDT_CTRL_FIELD_HI:`WDT_CTRL_FIELD_LO] = prescale_field;
    ctrl2_rd = 16'h0000;
    ctrl2_rd[`WDT_CTRL2_FLAG] = timeout_flag;
    ctrl2_rd[`WDT_CTRL2_MODE] = prescale_mode_select;
  end

  // one wait-free answer in the setup cycle; data held at access
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i
                   && !(hit(paddr_i, `WDT_OFF_COUNT)
                   || hit(paddr_i, `WDT_OFF_PERIOD)
                   || hit(paddr_i, `WDT_OFF_CTRL)
                   || hit(paddr_i, `WDT_OFF_CTRL2)
                   || hit(paddr_i, `WDT_OFF_STATUS)
                   || hit(paddr_i, `WDT_OFF_MASK));
      if (rd && !penable_i) begin
        unique case (paddr_i)
          `WDT_OFF_COUNT: prdata_o <= {16'h0000, watchdog_count};
          `WDT_OFF_PERIOD: prdata_o <= {16'h0000, watchdog_reload_period};
          `WDT_OFF_CTRL: prdata_o <= {16'h0000, ctrl_rd};
          `WDT_OFF_CTRL2: prdata_o <= {16'h0000, ctrl2_rd};
          `WDT_OFF_STATUS: prdata_o <= {16'h0000, timeout_flag, 15'h0000};
          `WDT_OFF_MASK: prdata_o <= {16'h0000, irq_mask, 15'h0000};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_halt_stop;
    halted && !free_bit && !soft_bit;
  endsequence

  // a count write is the only legal way to move a count stopped by halt
  sequence s_no_count_write;
    !(wr && hit(paddr_i, `WDT_OFF_COUNT));
  endsequence

  sequence s_apb_setup;
    psel_i && !penable_i;
  endsequence

  sequence s_ctrl_read;
    rd && !penable_i && hit(paddr_i, `WDT_OFF_CTRL);
  endsequence

  // debug halt behaviour and the plain decrement
  a_halt_stops: assert property ( // see R4
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_halt_stop ##0 s_no_count_write |=> $stable(watchdog_count))
    else $error("count moved during halt");
  a_soft_zero: assert property ( // see R5
    @(posedge mclk_i) disable iff (!rst_n_i)
    (halted && !free_bit && soft_bit && at_zero) ##0 s_no_count_write
    |=> at_zero)
    else $error("count left zero in soft halt");
  a_soft_runs: assert property ( // see R5
    @(posedge mclk_i) disable iff (!rst_n_i)
    halted && !free_bit && soft_bit && !at_zero && tick && !wr
    |=> watchdog_count == $past(watchdog_count) - 16'h0001)
    else $error("soft halt stopped before zero");
  a_free_runs: assert property ( // see R6
    @(posedge mclk_i) disable iff (!rst_n_i)
    free_bit && tick && !at_zero && !wr
    |=> watchdog_count == $past(watchdog_count) - 16'h0001)
    else $error("free-run decrement missing");
  a_decrement: assert property ( // see R2
    @(posedge mclk_i) disable iff (!rst_n_i)
    !wr && !timeout && !(run && tick) |=> $stable(watchdog_count))
    else $error("count changed without tick");

  // timeout, reload and interrupt
  a_reload_zero: assert property ( // see R3
    @(posedge mclk_i) disable iff (!rst_n_i)
    timeout && !wr
    |=> watchdog_count == $past(watchdog_reload_period) && timeout_flag)
    else $error("reload or flag missing at timeout");
  a_flag_pulse: assert property ( // see R12
    @(posedge mclk_i) disable iff (!rst_n_i)
    timeout |=> timeout_pulse_o && timeout_flag)
    else $error("timeout not signalled");
  a_irq_level: assert property ( // see R12
    @(posedge mclk_i) disable iff (!rst_n_i)
    timeout_flag && irq_mask |=> timeout_interrupt_o)
    else $error("interrupt not raised");
  a_irq_quiet: assert property ( // see R12
    @(posedge mclk_i) disable iff (!rst_n_i)
    !irq_mask |=> !timeout_interrupt_o)
    else $error("masked interrupt raised");

  // bus answers and what software sees
  a_ready_answer: assert property ( // see R1
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_apb_setup |=> pready_o)
    else $error("no ready after setup");
  a_period_write: assert property ( // see R3
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr && hit(paddr_i, `WDT_OFF_PERIOD)
    |=> watchdog_reload_period == $past(pwdata_i[15:0]))
    else $error("period write lost");
  a_mode_write: assert property ( // see R14
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr && hit(paddr_i, `WDT_OFF_CTRL2)
    |=> prescale_mode_select == $past(pwdata_i[`WDT_CTRL2_MODE]))
    else $error("mode write lost");
  // looks at the bus data, not at the mux that builds it
  a_ctrl_reserved: assert property ( // see R10
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_ctrl_read
    |=> prdata_o[31:12] == 20'h00000 && prdata_o[5:4] == 2'b00)
    else $error("reserved control bits not zero");
endmodule

// File: tb_wdt_core.sv
`timescale 1ns/1ps
`include "wdt_cfg.svh"
module tb_wdt_core;
  // ==========================================================
  // stimulus and observed signals
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic debug_halt_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic timeout_pulse_o;
  logic timeout_interrupt_o;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic er;
  int n;

  // clock at 200 MHz
  always #2.5 mclk_i = ~mclk_i;

  wdt_core u_wdt_core (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .debug_halt_i(debug_halt_i),
    .timeout_pulse_o(timeout_pulse_o),
    .timeout_interrupt_o(timeout_interrupt_o)
  );

  // ==========================================================
  // shared tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // cycles until the next timeout pulse
  task next_pulse(output int c);
    c = 0;
    do begin
      @(posedge mclk_i);
      c++;
    end while (timeout_pulse_o !== 1'b1);
  endtask

  // first two pulses only resynchronise after a setting change
  task measure(output int c);
    next_pulse(c);
    next_pulse(c);
    next_pulse(c);
  endtask

  task final_report;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task t_reset_and_reserved;
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    check(rd & 32'hfc3f, 32'h000f);
    apb(1'b0, `WDT_OFF_CTRL2, 32'h0);
    check(rd, 32'h1000);
    apb(1'b0, `WDT_OFF_PERIOD, 32'h0);
    check(rd, 32'hffff);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    check(rd, 32'hffff);
    apb(1'b1, `WDT_OFF_CTRL, 32'hffff);
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    check(rd & 32'hfc3f, 32'h0c0f);
    apb(1'b0, 12'h018, 32'h0);
    check({rd[30:0], er}, 32'h1);
  endtask

  // direct then indirect prescale; interval is (period+1)*(load+1)
  // the prescaler is not reloaded by writes, so the first direct tick
  // waits for its reset load of ffff to run out
  task t_prescale;
    apb(1'b1, `WDT_OFF_CTRL2, 32'h0);
    apb(1'b1, `WDT_OFF_CTRL, 32'h0002);
    apb(1'b1, `WDT_OFF_PERIOD, 32'h0003);
    apb(1'b1, `WDT_OFF_COUNT, 32'h0003);
    measure(n);
    check(n, 12);
    apb(1'b1, `WDT_OFF_CTRL2, 32'h1000);
    apb(1'b1, `WDT_OFF_PERIOD, 32'h0001);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `WDT_OFF_CTRL, k);
      measure(n);
      check(n, 2 << (k + 1));
    end
  endtask

  // timeout event, masking and write-one-to-clear
  task t_interrupt;
    apb(1'b1, `WDT_OFF_CTRL, 32'h0000);
    apb(1'b1, `WDT_OFF_PERIOD, 32'hffff);
    apb(1'b1, `WDT_OFF_COUNT, 32'hffff);
    apb(1'b0, `WDT_OFF_STATUS, 32'h0);
    check(rd, 32'h8000);
    check(timeout_interrupt_o, 1'b0);
    apb(1'b1, `WDT_OFF_MASK, 32'h8000);
    repeat (2) @(posedge mclk_i);
    check(timeout_interrupt_o, 1'b1);
    apb(1'b1, `WDT_OFF_STATUS, 32'h8000);
    repeat (2) @(posedge mclk_i);
    check(timeout_interrupt_o, 1'b0);
    apb(1'b0, `WDT_OFF_STATUS, 32'h0);
    check(rd, 32'h0);
  endtask

  // debug halt with both halt bits low, halt-at-zero alone, then both set, tick every clock
  task t_halt;
    apb(1'b1, `WDT_OFF_CTRL2, 32'h0);
    apb(1'b1, `WDT_OFF_COUNT, 32'h0100);
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    check(rd & 32'h03c0, 32'h0);
    debug_halt_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    rd2 = rd;
    repeat (10) @(posedge mclk_i);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    check(rd, rd2);
    apb(1'b1, `WDT_OFF_CTRL, 32'h0800);
    apb(1'b1, `WDT_OFF_COUNT, 32'h0003);
    repeat (20) @(posedge mclk_i);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `WDT_OFF_CTRL, 32'h0c00);
    apb(1'b1, `WDT_OFF_COUNT, 32'h0100);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    rd2 = rd;
    repeat (10) @(posedge mclk_i);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    check(rd2 - rd, 32'd13);
    debug_halt_i <= 1'b0;
  endtask

  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset_and_reserved();
    t_prescale();
    t_interrupt();
    t_halt();
    final_report();
  end

  // the one prescaler drain after reset makes a run about 66000 cycles
  initial begin
    #(5 * 80000);
    err_total++;
    final_report();
  end
endmodule
